/* File: core/slm_top.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "slm_params.svh"

module slm_top
  import slm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SLM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire slm_lock_cond_t [7:0] lock_cond,
  input wire logic [7:0] smp_valid,
  input wire slm_sample_t [7:0] smp_in,
  output logic [7:0] smp_out_valid,
  output slm_sample_t [7:0] smp_out,
  output logic irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic reg_hit(input logic [`SLM_ADDR_W-1:0] a, input logic [15:0] idx);
    reg_hit = (a[`SLM_IDX_LSB-1:0] == '0) && (a[`SLM_ADDR_W-1:`SLM_IDX_LSB] == idx);
  endfunction

  logic [15:0] lock_reg_ff;
  logic [15:0] mute_ff;
  logic [15:0] istat_ff;
  logic [15:0] imask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [7:0] out_valid_ff;
  slm_sample_t [7:0] out_ff;

  wire hit_lock = reg_hit(paddr, `SLM_IDX_LOCK);
  wire hit_mute = reg_hit(paddr, `SLM_IDX_MUTE);
  wire hit_istat = reg_hit(paddr, `SLM_IDX_ISTAT);
  wire hit_imask = reg_hit(paddr, `SLM_IDX_IMASK);
  wire hit_any = hit_lock | hit_mute | hit_istat | hit_imask;
  wire setup_ph = psel & ~penable;
  wire wr_do = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  wire [15:0] rd_sel = hit_lock ? (lock_reg_ff & `SLM_LOCK_RMASK) :
                       hit_mute ? mute_ff :
                       hit_istat ? istat_ff :
                       hit_imask ? imask_ff : `SLM_REG_RESET;
  wire [31:0] nxt_prdata = {16'h0000, rd_sel};

  // Response prepared in setup, so the access phase always takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & ~hit_any;
      prdata_ff <= (setup_ph & ~pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  wire [15:0] nxt_mute = wr_do & hit_mute ? (pwdata[15:0] & `SLM_MUTE_WMASK) : mute_ff;
  wire [15:0] nxt_imask = wr_do & hit_imask ? pwdata[15:0] : imask_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_ff <= `SLM_REG_RESET;
      imask_ff <= `SLM_REG_RESET;
    end else begin
      mute_ff <= nxt_mute;
      imask_ff <= nxt_imask;
    end
  end

  // ****************************************
  // Lock status and interrupt events
  // ****************************************
  logic [7:0] nxt_lock;
  wire lock_mute_en = mute_ff[`SLM_BIT_LOCK_LOSS];

  generate
    for (genvar i = 0; i < `SLM_PAIRS; i++) begin : g_lock
      // All three conditions or nothing
      assign nxt_lock[i] = &lock_cond[i];
    end
  endgenerate

  wire [7:0] lock_now = lock_reg_ff[7:0];
  wire [15:0] ev = {nxt_lock & ~lock_now, ~nxt_lock & lock_now};
  wire [15:0] w1c = (wr_do & hit_istat) ? pwdata[15:0] : 16'h0000;
  // New event beats a simultaneous write-one clear
  wire [15:0] nxt_istat = (istat_ff & ~w1c) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg_ff <= `SLM_REG_RESET;
      istat_ff <= `SLM_REG_RESET;
      irq_ff <= 1'b0;
    end else begin
      lock_reg_ff <= {8'h00, nxt_lock};
      istat_ff <= nxt_istat;
      irq_ff <= |(nxt_istat & imask_ff);
    end
  end

  // ****************************************
  // Per-pair mute ramp
  // ****************************************
  slm_ramp_st_t [7:0] st_ff;
  logic [7:0][`SLM_GAIN_W-1:0] gain_ff;
  logic [7:0] ramp_off;
  logic [7:0] mute_tgt;

  generate
    for (genvar i = 0; i < `SLM_PAIRS; i++) begin : g_pair
      slm_ramp_st_t nxt_st;
      logic [`SLM_GAIN_W-1:0] nxt_gain;
      logic signed [36:0] prod_l;
      logic signed [36:0] prod_r;

      assign ramp_off[i] = mute_ff[`SLM_BIT_RAMP0 + i / `SLM_GROUP_SIZE];
      // Manual mute overrides lock recovery; disable overrides both
      assign mute_tgt[i] = ~ramp_off[i] &
        (mute_ff[i] | (lock_mute_en & ~lock_now[i]));

      always_comb begin
        nxt_st = st_ff[i];
        case (st_ff[i])
          SLM_OPEN: begin
            if (mute_tgt[i]) nxt_st = SLM_FALL;
          end
          // A turn caught at either end would otherwise strand the state
          SLM_FALL: begin
            if (!mute_tgt[i]) nxt_st = SLM_RISE;
            else if (gain_ff[i] == `SLM_GAIN_ZERO) nxt_st = SLM_SHUT;
            else if (smp_valid[i] && gain_ff[i] == `SLM_GAIN_STEP) nxt_st = SLM_SHUT;
          end
          SLM_SHUT: begin
            if (!mute_tgt[i]) nxt_st = SLM_RISE;
          end
          SLM_RISE: begin
            if (mute_tgt[i]) nxt_st = SLM_FALL;
            else if (gain_ff[i] == `SLM_GAIN_UNITY) nxt_st = SLM_OPEN;
            else if (smp_valid[i] && gain_ff[i] == `SLM_GAIN_UNITY - `SLM_GAIN_STEP)
              nxt_st = SLM_OPEN;
          end
          default: nxt_st = SLM_OPEN;
        endcase
        if (ramp_off[i]) nxt_st = SLM_OPEN;
      end

      // One gain step per input sample: 2048 steps between silence and unity
      always_comb begin
        nxt_gain = gain_ff[i];
        if (ramp_off[i]) nxt_gain = `SLM_GAIN_UNITY;
        else if (smp_valid[i] && st_ff[i] == SLM_FALL && gain_ff[i] != `SLM_GAIN_ZERO)
          nxt_gain = gain_ff[i] - `SLM_GAIN_STEP;
        else if (smp_valid[i] && st_ff[i] == SLM_RISE && gain_ff[i] != `SLM_GAIN_UNITY)
          nxt_gain = gain_ff[i] + `SLM_GAIN_STEP;
      end

      assign prod_l = $signed(smp_in[i].left) * $signed({1'b0, gain_ff[i]});
      assign prod_r = $signed(smp_in[i].right) * $signed({1'b0, gain_ff[i]});

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_ff[i] <= SLM_OPEN;
          gain_ff[i] <= `SLM_GAIN_UNITY;
          out_ff[i] <= '0;
          out_valid_ff[i] <= 1'b0;
        end else begin
          st_ff[i] <= nxt_st;
          gain_ff[i] <= nxt_gain;
          out_valid_ff[i] <= smp_valid[i];
          if (smp_valid[i]) begin
            out_ff[i].left <= prod_l[`SLM_GAIN_SHIFT+23:`SLM_GAIN_SHIFT];
            out_ff[i].right <= prod_r[`SLM_GAIN_SHIFT+23:`SLM_GAIN_SHIFT];
          end
        end
      end

      // ****************************************
      // Checks per pair
      // ****************************************
      property p_gain_fall;
        @(posedge pclk) disable iff (!presetn)
        (smp_valid[i] && st_ff[i] == SLM_FALL && !ramp_off[i] && gain_ff[i] != 12'h000)
          |=> (gain_ff[i] == $past(gain_ff[i]) - 12'h001);
      endproperty
      a_gain_fall: assert property (p_gain_fall) else $error("fall step wrong");

      property p_gain_rise;
        @(posedge pclk) disable iff (!presetn)
        (smp_valid[i] && st_ff[i] == SLM_RISE && !ramp_off[i] &&
          gain_ff[i] != `SLM_GAIN_UNITY)
          |=> (gain_ff[i] == $past(gain_ff[i]) + `SLM_GAIN_STEP);
      endproperty
      a_gain_rise: assert property (p_gain_rise) else $error("rise step wrong");

      property p_fall_end;
        @(posedge pclk) disable iff (!presetn)
        (smp_valid[i] && st_ff[i] == SLM_FALL && mute_tgt[i] &&
          gain_ff[i] == `SLM_GAIN_STEP)
          |=> (st_ff[i] == SLM_SHUT && gain_ff[i] == `SLM_GAIN_ZERO);
      endproperty
      a_fall_end: assert property (p_fall_end) else $error("ramp end wrong");

      // Steps of one either way: a cut downward is as audible as a jump up
      property p_no_jump;
        @(posedge pclk) disable iff (!presetn)
        (!ramp_off[i] && $past(!ramp_off[i]) && gain_ff[i] != $past(gain_ff[i]))
          |-> (gain_ff[i] - $past(gain_ff[i]) == 12'h001 ||
               $past(gain_ff[i]) - gain_ff[i] == 12'h001);
      endproperty
      a_no_jump: assert property (p_no_jump) else $error("gain jumped");

      property p_auto_mute;
        @(posedge pclk) disable iff (!presetn)
        (lock_mute_en && !lock_now[i] && !ramp_off[i] && st_ff[i] == SLM_OPEN)
          |=> (st_ff[i] == SLM_FALL);
      endproperty
      a_auto_mute: assert property (p_auto_mute) else $error("no lock-loss mute");

      property p_manual_hold;
        @(posedge pclk) disable iff (!presetn)
        (mute_ff[i] && !ramp_off[i]) [*2]
          |-> (st_ff[i] == SLM_FALL || st_ff[i] == SLM_SHUT);
      endproperty
      a_manual_hold: assert property (p_manual_hold) else $error("manual mute lost");

      property p_disable_unity;
        @(posedge pclk) disable iff (!presetn)
        ramp_off[i] |=> (gain_ff[i] == 12'h800 && st_ff[i] == SLM_OPEN);
      endproperty
      a_disable_unity: assert property (p_disable_unity) else $error("group not open");

      property p_turn;
        @(posedge pclk) disable iff (!presetn)
        (st_ff[i] == SLM_FALL && !mute_tgt[i] && !smp_valid[i] && !ramp_off[i])
          |=> (st_ff[i] == SLM_RISE && $stable(gain_ff[i]));
      endproperty
      a_turn: assert property (p_turn) else $error("ramp did not turn");

      property p_unmute;
        @(posedge pclk) disable iff (!presetn)
        (st_ff[i] == SLM_SHUT && lock_now[i] && !mute_ff[i] && !ramp_off[i])
          |=> (st_ff[i] == SLM_RISE);
      endproperty
      a_unmute: assert property (p_unmute) else $error("no unmute on lock");
    end
  endgenerate

  // ****************************************
  // Global checks
  // ****************************************
  property p_lock_set;
    @(posedge pclk) disable iff (!presetn)
    (&lock_cond[0]) |=> lock_reg_ff[0];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  property p_lock_clr;
    @(posedge pclk) disable iff (!presetn)
    !(&lock_cond[7]) |=> !lock_reg_ff[7];
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock not cleared");

  property p_lock_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_lock) |=> (prdata_ff[31:8] == 24'h00_0000 && pready_ff);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

  property p_mute_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_do && hit_mute) |=> (mute_ff[7:0] == $past(pwdata[7:0]));
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("mute write lost");

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign smp_out_valid = out_valid_ff;
  assign smp_out = out_ff;

endmodule

/* File: inc/slm_params.svh */
`ifndef SLM_PARAMS_SVH
`define SLM_PARAMS_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define SLM_IDX_LOCK 16'hf580
`define SLM_IDX_MUTE 16'hf581
`define SLM_IDX_ISTAT 16'hf582
`define SLM_IDX_IMASK 16'hf583
`define SLM_ADDR_W 18
`define SLM_IDX_LSB 2
// ****************************************
// Field layout and reset values
// ****************************************
`define SLM_REG_RESET 16'h0000
`define SLM_LOCK_RMASK 16'h00ff
`define SLM_MUTE_WMASK 16'h07ff
`define SLM_BIT_RAMP0 8
`define SLM_BIT_LOCK_LOSS 10
`define SLM_GROUP_SIZE 4
`define SLM_PAIRS 8
// ****************************************
// Ramp timing
// ****************************************
`define SLM_RAMP_SAMPLES 2048
`define SLM_GAIN_W 12
`define SLM_GAIN_SHIFT 11
`define SLM_GAIN_UNITY 12'h800
`define SLM_GAIN_ZERO 12'h000
`define SLM_GAIN_STEP 12'h001
`endif

/* File: inc/slm_pkg.sv */
package slm_pkg;
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } slm_sample_t;

  typedef struct packed {
    logic target_set;
    logic rate_steady;
    logic ratio_done;
  } slm_lock_cond_t;

  // Gray codes along open -> fall -> shut -> rise
  typedef enum logic [1:0] {
    SLM_OPEN = 2'b00,
    SLM_FALL = 2'b01,
    SLM_SHUT = 2'b11,
    SLM_RISE = 2'b10
  } slm_ramp_st_t;
endpackage

/* File: tb/slm_partner.sv */
`timescale 1ns/10ps
// ****************************************
// Converter datapath stand-in
// ****************************************
module slm_partner
  import slm_pkg::*;
(
  input wire logic pclk,
  output slm_lock_cond_t [7:0] lock_cond,
  output logic [7:0] smp_valid,
  output slm_sample_t [7:0] smp_in
);
  initial begin
    lock_cond = '0;
    smp_valid = '0;
    smp_in = '0;
  end
  task automatic set_lock(input logic [23:0] c);
    @(posedge pclk);
    lock_cond <= c;
  endtask
  // Level of +-2048 in, so the left output reads back the gain itself and the right output its negative
  task automatic send(input int p, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      smp_valid[p] <= 1'b1;
      smp_in[p] <= 48'h0008_00ff_f800;
    end
    @(posedge pclk);
    smp_valid[p] <= 1'b0;
    // Stale data inverted so nothing leans on a held value
    smp_in[p] <= 48'hfff7_ff00_07ff;
  endtask
endmodule

/* File: tb/tb_slm_top.sv */
`timescale 1ns/10ps
`include "slm_params.svh"
// ****************************************
// Register and ramp bench
// ****************************************
module tb_slm_top
  import slm_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [`SLM_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  slm_lock_cond_t [7:0] lock_cond;
  logic [7:0] smp_valid, smp_out_valid, lx;
  slm_sample_t [7:0] smp_in, smp_out;
  int n_fail, checks_done, cyc;
  logic [32:0] rq[$];
  logic [23:0] sq[8][$];
  logic [32:0] r;
  logic [23:0] e, c;

  always #2 pclk = ~pclk;
  slm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .lock_cond, .smp_valid, .smp_in, .smp_out_valid, .smp_out, .irq);
  slm_partner u_src (.pclk, .lock_cond, .smp_valid, .smp_in);

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                     input logic [15:0] exp, input logic err);
    rq.push_back({err, 16'h0000, exp});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 16'h0000, 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic lk(input logic [23:0] v);
    u_src.set_lock(v);
    repeat (4) @(posedge pclk);
  endtask
  // Expected gains g, g+d, ... for n samples on pair p
  task automatic ramp(input int p, input int g, input int d, input int n);
    for (int k = 0; k < n; k++) sq[p].push_back(24'(g + d * k));
    u_src.send(p, n);
    repeat (3) @(posedge pclk);
  endtask

  // ****************************************
  // Result watchers
  // ****************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      r = rq.pop_front();
      chk("prdata", prdata, r[31:0]);
      chk("pslverr", 32'(pslverr), 32'(r[32]));
    end
    for (int i = 0; i < 8; i++) begin
      if (smp_out_valid[i] === 1'b1) begin
        e = sq[i].size() > 0 ? sq[i].pop_front() : 24'hff_ffff;
        chk("left", smp_out[i].left, e);
        chk("right", smp_out[i].right, 24'(0 - e));
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(15));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) apb(1'b0, `SLM_IDX_LOCK + 16'(i), 0, 0, 1'b0);
    apb(1'b1, 16'hf584, 16'hffff, 0, 1'b1);
    apb(1'b0, 16'hf584, 0, 0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      c = 24'($urandom);
      lk(c);
      for (int j = 0; j < 8; j++) lx[j] = &c[3*j+:3];
      apb(1'b0, `SLM_IDX_LOCK, 16'hffff, {8'h00, lx}, 1'b0);
    end
    lk(24'h00_0000);
    for (int p = 0; p < 8; p++) ramp(p, 2048, 0, 1);
    // Interrupt raise, mask, clear
    lk(24'hff_ffff);
    wr(`SLM_IDX_ISTAT, 16'hffff);
    wr(`SLM_IDX_IMASK, 16'h0001);
    lk(24'hff_fff8);
    chk("irq", 32'(irq), 1);
    apb(1'b0, `SLM_IDX_ISTAT, 0, 16'h0001, 1'b0);
    wr(`SLM_IDX_IMASK, 16'h0000);
    chk("irq", 32'(irq), 0);
    wr(`SLM_IDX_IMASK, 16'h0001);
    chk("irq", 32'(irq), 1);
    wr(`SLM_IDX_ISTAT, 16'h0001);
    chk("irq", 32'(irq), 0);
    lk(24'hff_ffff);
    // Manual mute, full ramps and a reversal
    wr(`SLM_IDX_MUTE, 16'hffff);
    apb(1'b0, `SLM_IDX_MUTE, 0, 16'h07ff, 1'b0);
    wr(`SLM_IDX_MUTE, 16'h0001);
    ramp(0, 2048, -1, 2049);
    wr(`SLM_IDX_MUTE, 16'h0000);
    ramp(0, 0, 1, 100);
    wr(`SLM_IDX_MUTE, 16'h0001);
    ramp(0, 100, -1, 101);
    wr(`SLM_IDX_MUTE, 16'h0000);
    ramp(0, 0, 1, 2049);
    // Group disable only touches pairs 0 to 3
    wr(`SLM_IDX_MUTE, 16'h0111);
    ramp(0, 2048, 0, 3);
    ramp(4, 2048, -1, 3);
    wr(`SLM_IDX_MUTE, 16'h0000);
    ramp(4, 2045, 1, 4);
    // Lock-loss mute, regain and manual priority
    wr(`SLM_IDX_MUTE, 16'h0400);
    lk(24'hff_ffc7);
    ramp(1, 2048, -1, 2049);
    lk(24'hff_ffff);
    ramp(1, 0, 1, 2049);
    wr(`SLM_IDX_MUTE, 16'h0402);
    ramp(1, 2048, -1, 2049);
    lk(24'hff_ffc7);
    lk(24'hff_ffff);
    ramp(1, 0, 0, 3);
    wr(`SLM_IDX_MUTE, 16'h0600);
    lk(24'hfc_7fff);
    ramp(5, 2048, 0, 2);
    for (int p = 0; p < 8; p++) chk("left over", sq[p].size(), 0);
    finish_test();
  end
endmodule
